// ==== rtl/i2c_port_cfg.svh ====
// Constants for the two-wire register port: addresses, layout and timing
`ifndef I2C_PORT_CFG_SVH
`define I2C_PORT_CFG_SVH

// ----------------------------------------------------------------------
// Bus addresses
// ----------------------------------------------------------------------
`define DEV_WR_BYTE 8'hb0
`define DEV_RD_BYTE 8'hb1
`define OWN_ADDR10 10'h058
`define TEN_HDR 5'h1e
`define GCALL_BYTE 8'h00

// ----------------------------------------------------------------------
// Register space
// ----------------------------------------------------------------------
`define TOUCH_FIFO_ADDR 8'h18
`define PWM_PORT_ADDR 8'hc0
`define PTR_RESET 8'h00
`define WR_FIFO_DEPTH 16

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define FAST_BIT_NS 2500
`define STD_BIT_NS 10000
`define FAST_HALF_CYC ((`FAST_BIT_NS / 2) / `CLK_PERIOD_NS)

`endif

// ==== rtl/i2c_port_pkg.sv ====
// Types shared by the two-wire register port
package i2c_port_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } wr_word_s;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_STALL, ST_ACK, ST_TX, ST_MACK, ST_IGNORE
  } state_e;

  typedef enum logic [2:0] {
    PH_DEV, PH_DEV10, PH_REG, PH_DATA, PH_GCALL
  } phase_e;

endpackage

// ==== rtl/i2c_slave_register_port.sv ====
// Two-wire slave port into an 8-bit register space, with its write FIFO
`include "i2c_port_cfg.svh"

// ----------------------------------------------------------------------
// Write FIFO
// ----------------------------------------------------------------------
module wr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q, rd_q;
  logic push, pop;

  assign in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (ce) begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

// ----------------------------------------------------------------------
// Slave port
// ----------------------------------------------------------------------
module i2c_slave_register_port (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_CE,
  input wire logic I_SCL,
  output logic O_SCL_O,
  output logic O_SCL_OE,
  input wire logic I_SDA,
  output logic O_SDA_O,
  output logic O_SDA_OE,
  output logic O_WR_VALID,
  input wire logic I_WR_READY,
  output i2c_port_pkg::wr_word_s O_WR_WORD,
  output logic O_RD_TAKE,
  output logic [7:0] O_RD_ADDR,
  input wire logic [7:0] I_RD_DATA
);
  import i2c_port_pkg::*;
  logic [2:0] scl_s_q, sda_s_q;
  logic scl_q, sda_q, scl_p_q, sda_p_q, scl_rise, scl_fall, start_ev, stop_ev;
  state_e state_q;
  phase_e phase_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q, ptr_q;
  logic sda_oe_q, rd_q, ten_q, mack_q, byte_done, take, reg_load, push, fifo_ready;
  wr_word_s push_word;

  // Stay on the same register for the touch FIFO on reads and the PWM port on writes
  function automatic logic [7:0] next_ptr(input logic [7:0] p, input logic is_wr);
    return ((!is_wr && p == `TOUCH_FIFO_ADDR) || (is_wr && p == `PWM_PORT_ADDR))
      ? p : p + 8'h01;
  endfunction

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  // Three stages: about 40 ns of lag, far below a fast-mode half period
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (I_CE) begin
      scl_s_q <= {scl_s_q[1:0], I_SCL};
      sda_s_q <= {sda_s_q[1:0], I_SDA};
      if (scl_s_q[1] == scl_s_q[2]) begin
        scl_q <= scl_s_q[2];
      end
      if (sda_s_q[1] == sda_s_q[2]) begin
        sda_q <= sda_s_q[2];
      end
      scl_p_q <= scl_q;
      sda_p_q <= sda_q;
    end
  end

  assign scl_rise = scl_q && !scl_p_q;
  assign scl_fall = !scl_q && scl_p_q;
  assign start_ev = scl_q && scl_p_q && sda_p_q && !sda_q;
  assign stop_ev = scl_q && scl_p_q && !sda_p_q && sda_q;
  assign byte_done = state_q == ST_RX && scl_fall && bit_cnt_q == 4'h8;
  assign reg_load = byte_done && phase_q == PH_REG;
  assign take = scl_fall && ((state_q == ST_ACK && rd_q) || (state_q == ST_MACK && mack_q));
  assign push = state_q == ST_STALL && fifo_ready;
  assign push_word = '{addr: ptr_q, data: shift_q};

  // --------------------------------------------------------------------
  // Protocol state machine
  // --------------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      state_q <= ST_IDLE;
      phase_q <= PH_DEV;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      sda_oe_q <= 1'b0;
      rd_q <= 1'b0;
      ten_q <= 1'b0;
      mack_q <= 1'b0;
    end else if (I_CE) begin
      if (start_ev) begin
        state_q <= ST_RX;
        phase_q <= PH_DEV;
        bit_cnt_q <= 4'h0;
        sda_oe_q <= 1'b0;
        rd_q <= 1'b0;
      end else if (stop_ev) begin
        state_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
        rd_q <= 1'b0;
        ten_q <= 1'b0;
      end else if (take) begin
        state_q <= ST_TX;
        shift_q <= I_RD_DATA;
        sda_oe_q <= !I_RD_DATA[7];
        bit_cnt_q <= 4'h0;
      end else begin
        case (state_q)
          ST_RX: begin
            if (scl_rise && bit_cnt_q != 4'h8) begin
              shift_q <= {shift_q[6:0], sda_q};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (byte_done) begin
              state_q <= ST_ACK;
              sda_oe_q <= 1'b1;
              case (phase_q)
                PH_DEV: begin
                  if (shift_q == `DEV_WR_BYTE || shift_q == `DEV_RD_BYTE) begin
                    rd_q <= shift_q[0];
                    phase_q <= shift_q[0] ? PH_DATA : PH_REG;
                  end else if (shift_q == `GCALL_BYTE) begin
                    phase_q <= PH_GCALL;
                  end else if (shift_q[7:3] == `TEN_HDR
                               && shift_q[2:1] == 2'(`OWN_ADDR10 >> 8)
                               && (!shift_q[0] || ten_q)) begin
                    rd_q <= shift_q[0];
                    phase_q <= shift_q[0] ? PH_DATA : PH_DEV10;
                  end else begin
                    state_q <= ST_IGNORE;
                    sda_oe_q <= 1'b0;
                  end
                end
                PH_DEV10: begin
                  if (shift_q == 8'(`OWN_ADDR10)) begin
                    ten_q <= 1'b1;
                    phase_q <= PH_REG;
                  end else begin
                    state_q <= ST_IGNORE;
                    sda_oe_q <= 1'b0;
                  end
                end
                PH_REG: phase_q <= PH_DATA;
                PH_DATA: begin
                  state_q <= ST_STALL;
                  sda_oe_q <= 1'b0;
                end
                default: ;
              endcase
            end
          end
          ST_STALL: begin
            if (push) begin
              state_q <= ST_ACK;
              sda_oe_q <= 1'b1;
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              state_q <= ST_RX;
              sda_oe_q <= 1'b0;
              bit_cnt_q <= 4'h0;
            end
          end
          ST_TX: begin
            if (scl_fall && bit_cnt_q == 4'h7) begin
              state_q <= ST_MACK;
              sda_oe_q <= 1'b0;
            end else if (scl_fall) begin
              shift_q <= {shift_q[6:0], 1'b0};
              sda_oe_q <= !shift_q[6];
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              mack_q <= !sda_q;
            end else if (scl_fall) begin
              state_q <= ST_IGNORE;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Register pointer
  // --------------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      ptr_q <= `PTR_RESET;
    end else if (I_CE) begin
      if (reg_load) begin
        ptr_q <= shift_q;
      end else if (push) begin
        ptr_q <= next_ptr(ptr_q, 1'b1);
      end else if (take && !start_ev && !stop_ev) begin
        ptr_q <= next_ptr(ptr_q, 1'b0);
      end
    end
  end

  // Writes are queued; a full queue stretches the clock instead of losing bytes
  wr_fifo #(.WIDTH($bits(wr_word_s)), .DEPTH(`WR_FIFO_DEPTH)) u_fifo (
    .clk(I_CLK),
    .nrst(I_NRST),
    .ce(I_CE),
    .in_valid(state_q == ST_STALL),
    .in_ready(fifo_ready),
    .in_data(push_word),
    .out_valid(O_WR_VALID),
    .out_ready(I_WR_READY),
    .out_data(O_WR_WORD)
  );

  assign O_SCL_O = 1'b0;
  assign O_SDA_O = 1'b0;
  assign O_SCL_OE = state_q == ST_STALL;
  assign O_SDA_OE = sda_oe_q;
  assign O_RD_TAKE = take && !start_ev && !stop_ev;
  assign O_RD_ADDR = ptr_q;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  chk_start_rx: assert property (@(posedge I_CLK) disable iff (!I_NRST || !I_CE)
    start_ev |=> state_q == ST_RX && bit_cnt_q == 4'h0 && !O_SDA_OE)
    else $error("start not taken");
  chk_idle_quiet: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    state_q == ST_IDLE |-> !O_SDA_OE && !O_RD_TAKE && !O_SCL_OE)
    else $error("bus driven while idle");
  chk_stop_idle: assert property (@(posedge I_CLK) disable iff (!I_NRST || !I_CE)
    stop_ev |=> state_q == ST_IDLE ##1 !O_SDA_OE) else $error("stop did not end transfer");
  chk_ack_own_addr: assert property (@(posedge I_CLK) disable iff (!I_NRST || !I_CE)
    byte_done && phase_q == PH_DEV && shift_q == `DEV_WR_BYTE |=> O_SDA_OE && phase_q == PH_REG)
    else $error("own address not acknowledged");
  chk_nack_foreign: assert property (@(posedge I_CLK) disable iff (!I_NRST || !I_CE)
    byte_done && phase_q == PH_DEV && shift_q[7:1] == 7'h59
    |=> (!O_SDA_OE && state_q == ST_IGNORE) [*3])
    else $error("foreign address answered");
  chk_read_incr: assert property (@(posedge I_CLK) disable iff (!I_NRST || !I_CE)
    O_RD_TAKE && ptr_q != `TOUCH_FIFO_ADDR |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("read pointer not advanced");
  chk_fifo_hold: assert property (@(posedge I_CLK) disable iff (!I_NRST || !I_CE)
    O_RD_TAKE && ptr_q == `TOUCH_FIFO_ADDR |=> $stable(ptr_q))
    else $error("touch FIFO address moved");
  chk_pwm_hold: assert property (@(posedge I_CLK) disable iff (!I_NRST || !I_CE)
    push && ptr_q == `PWM_PORT_ADDR |=> $stable(ptr_q) && state_q == ST_ACK)
    else $error("PWM port address moved");
  chk_no_write_after_stop: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    stop_ev |-> !push && state_q != ST_STALL)
    else $error("write after stop");
  chk_reg_load: assert property (@(posedge I_CLK) disable iff (!I_NRST || !I_CE)
    reg_load |=> ptr_q == $past(shift_q) && phase_q == PH_DATA)
    else $error("register address not loaded");
  chk_bit_release: assert property (@(posedge I_CLK) disable iff (!I_NRST || !I_CE)
    state_q == ST_TX && scl_fall && bit_cnt_q == 4'h7 |=> !O_SDA_OE && state_q == ST_MACK)
    else $error("data not released after eight bits");

  cov_write: cover property (@(posedge I_CLK) push);
  cov_read: cover property (@(posedge I_CLK) O_RD_TAKE ##[1:1000] O_RD_TAKE);
  cov_stretch: cover property (@(posedge I_CLK) O_SCL_OE && !fifo_ready);
  cov_gcall: cover property (@(posedge I_CLK) phase_q == PH_GCALL && state_q == ST_ACK);
endmodule

// ==== testbench/i2c_host_model.sv ====
// Behavioural two-wire bus master that drives the register port
module i2c_host_model (
  output logic scl_low,
  output logic sda_low,
  input wire logic scl_in,
  input wire logic sda_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------------
  // Data moves mid low phase so its setup covers the slave's input filter lag
  localparam int T = 80;
  logic stretched;

  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    stretched = 1'b0;
  end

  // The slave may hold the clock low while its FIFO is full
  task automatic rise();
    int n;
    scl_low = 1'b0;
    n = 0;
    #1;
    while (scl_in !== 1'b1 && n < 10000) begin
      #10;
      n++;
      stretched = 1'b1;
    end
  endtask

  task automatic put_bit(input logic b, output logic got);
    scl_low = 1'b1;
    #T;
    sda_low = ~b;
    #T;
    rise();
    got = sda_in;
    #T;
  endtask

  task automatic start();
    scl_low = 1'b1;
    #T;
    sda_low = 1'b0;
    #T;
    rise();
    #T;
    sda_low = 1'b1;
    #T;
  endtask

  task automatic stop();
    scl_low = 1'b1;
    #T;
    sda_low = 1'b1;
    #T;
    rise();
    #T;
    sda_low = 1'b0;
    #T;
  endtask

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) put_bit(b[i], g);
    put_bit(1'b1, g);
    ack = ~g;
  endtask

  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, g);
      d[i] = g;
    end
    put_bit(~mack, g);
  endtask
endmodule

// ==== testbench/i2c_slave_register_port_test.sv ====
// Self-checking bench for the two-wire register port and its write FIFO
module i2c_slave_register_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  import i2c_port_pkg::*;
  typedef struct packed {logic rd; logic [7:0] reg_a; logic [7:0] n; logic [7:0] ptr;} row_s;
  // ----------------------------------------------------------------------
  // Bench signals
  // ----------------------------------------------------------------------
  logic clk, nrst, wr_ready, ack, scl_low, sda_low, scl_wire, sda_wire;
  logic scl_o, scl_oe, sda_o, sda_oe, wr_valid, rd_take;
  logic [7:0] rd_addr, rd_data;
  wr_word_s wr_word;
  wr_word_s got_q[$];
  wr_word_s exp_q[$];
  int n_fail, num_checks, cyc;
  row_s rows[5] = '{'{1'b0, 8'h10, 8'h03, 8'h13}, '{1'b0, 8'hc0, 8'h03, 8'hc0},
    '{1'b0, 8'hfe, 8'h03, 8'h01}, '{1'b1, 8'h20, 8'h03, 8'h23}, '{1'b1, 8'h18, 8'h03, 8'h18}};

  always #5 clk = ~clk;
  // Open-drain wires with pull-ups
  assign scl_wire = (scl_low | (scl_oe & ~scl_o)) ? 1'b0 : 1'b1;
  assign sda_wire = (sda_low | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;
  assign rd_data = rdf(rd_addr);

  i2c_slave_register_port i_dut (.I_CLK(clk), .I_NRST(nrst), .I_CE(1'b1), .I_SCL(scl_wire),
    .O_SCL_O(scl_o), .O_SCL_OE(scl_oe), .I_SDA(sda_wire), .O_SDA_O(sda_o),
    .O_SDA_OE(sda_oe), .O_WR_VALID(wr_valid), .I_WR_READY(wr_ready), .O_WR_WORD(wr_word),
    .O_RD_TAKE(rd_take), .O_RD_ADDR(rd_addr), .I_RD_DATA(rd_data));
  i2c_host_model i_host (.scl_low(scl_low), .sda_low(sda_low), .scl_in(scl_wire),
    .sda_in(sda_wire));

  function automatic logic [7:0] rdf(input logic [7:0] a);
    return {a[3:0], a[7:4]} ^ 8'h3c;
  endfunction

  function automatic logic [7:0] step(input logic rd, input logic [7:0] a);
    return ((rd && a == 8'h18) || (!rd && a == 8'hc0)) ? 8'h00 : 8'h01;
  endfunction

  always @(posedge clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) got_q.push_back(wr_word);
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------------
  // Checks and transfers
  // ----------------------------------------------------------------------
  task automatic chk_bit(input logic g, input logic e, input string m);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %b exp %b", $time, m, g, e);
    end
  endtask

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic chk_word(input wr_word_s g, input wr_word_s e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED at %0t: fifo word got %h exp %h", $time, g, e);
    end
  endtask

  task automatic send(input logic [7:0] b, input logic e, input string m);
    i_host.wr_byte(b, ack);
    chk_bit(ack, e, m);
  endtask

  task automatic expect_words();
    repeat (20) @(negedge clk);
    chk_byte(8'(got_q.size()), 8'(exp_q.size()), "word count");
    while (got_q.size() > 0 && exp_q.size() > 0) chk_word(got_q.pop_front(), exp_q.pop_front());
    got_q.delete();
    exp_q.delete();
  endtask

  task automatic wr_txn(input logic [7:0] a, input int n, input logic [7:0] ptr);
    logic [7:0] p;
    p = a;
    i_host.start();
    send(8'hb0, 1'b1, "write select");
    send(a, 1'b1, "register address");
    for (int i = 0; i < n; i++) begin
      send(a ^ 8'(i + 90), 1'b1, "write data");
      exp_q.push_back({p, a ^ 8'(i + 90)});
      p = p + step(1'b0, a);
    end
    i_host.stop();
    expect_words();
    chk_byte(rd_addr, ptr, "pointer after write");
  endtask

  task automatic rd_txn(input logic [7:0] a, input int n, input logic [7:0] ptr);
    logic [7:0] p, d;
    p = a;
    i_host.start();
    send(8'hb0, 1'b1, "write select");
    send(a, 1'b1, "register address");
    i_host.start();
    send(8'hb1, 1'b1, "read select");
    for (int i = 0; i < n; i++) begin
      i_host.rd_byte(i < n - 1, d);
      chk_byte(d, rdf(p), "read data");
      p = p + step(1'b1, a);
    end
    i_host.stop();
    repeat (10) @(negedge clk);
    chk_byte(rd_addr, ptr, "pointer after read");
  endtask

  task automatic end_test(input string name);
    $display("test %s finished, failures so far %0d", name, n_fail);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    wr_ready = 1'b1;
    n_fail = 0;
    num_checks = 0;
    cyc = 0;
    repeat (2) @(negedge clk);
    chk_bit(sda_oe, 1'b0, "data drive in reset");
    chk_bit(wr_valid, 1'b0, "fifo valid in reset");
    chk_byte(rd_addr, 8'h00, "pointer in reset");
    nrst = 1'b1;
    repeat (8) @(negedge clk);
    end_test("reset");
    foreach (rows[k]) begin
      if (rows[k].rd) rd_txn(rows[k].reg_a, int'(rows[k].n), rows[k].ptr);
      else wr_txn(rows[k].reg_a, int'(rows[k].n), rows[k].ptr);
    end
    end_test("table");
    send(8'hb0, 1'b0, "select without start");
    i_host.stop();
    i_host.start();
    send(8'hb2, 1'b0, "foreign select");
    send(8'h33, 1'b0, "foreign data");
    i_host.stop();
    expect_words();
    end_test("ignored traffic");
    i_host.start();
    send(8'h00, 1'b1, "general call");
    send(8'h5a, 1'b1, "general call data");
    i_host.stop();
    expect_words();
    i_host.start();
    send(8'hf0, 1'b1, "ten-bit header");
    send(8'h58, 1'b1, "ten-bit low byte");
    send(8'h40, 1'b1, "register address");
    send(8'h9e, 1'b1, "ten-bit data");
    i_host.stop();
    exp_q.push_back({8'h40, 8'h9e});
    expect_words();
    end_test("general call and ten-bit");
    i_host.start();
    send(8'hb0, 1'b1, "write select");
    send(8'h60, 1'b1, "register address");
    send(8'h11, 1'b1, "write data");
    exp_q.push_back({8'h60, 8'h11});
    repeat (4) i_host.put_bit(1'b0, ack);
    i_host.stop();
    expect_words();
    end_test("stop inside byte");
    @(negedge clk);
    wr_ready = 1'b0;
    i_host.stretched = 1'b0;
    fork
      begin
        wait (i_host.stretched === 1'b1);
        #3000;
        @(negedge clk);
        chk_bit(wr_valid, 1'b1, "full fifo holds words");
        wr_ready = 1'b1;
      end
    join_none
    wr_txn(8'h70, 17, 8'h81);
    chk_bit(i_host.stretched, 1'b1, "clock held while fifo full");
    end_test("fifo fill and drain");
    tally_and_finish();
  end
endmodule
